// ### common/tbf_map.vh
`ifndef TBF_MAP_VH
`define TBF_MAP_VH

// Outer block framing characters and the ASCII digit base
`define TBF_CHR_HASH      8'h23
`define TBF_CHR_LF        8'h0A
`define TBF_CHR_ZERO      8'h30

// Data type designator: 4-byte float, least significant byte first
`define TBF_CHR_TYPE_F    8'h66
`define TBF_VAL_BYTES     4

// Fixed part of a section: tag, type byte, count digit
`define TBF_TAG_LEN       3
`define TBF_SEC_FIXED     5

// Result tags, byte 0 first
`define TBF_TAG_AVG       24'h41_5647
`define TBF_TAG_MIN       24'h4D_494E
`define TBF_TAG_MAX       24'h4D_4158
`define TBF_TAG_RND       24'h52_4E44

// Section indices and order
`define TBF_SEC_AVG       2'h0
`define TBF_SEC_MIN       2'h1
`define TBF_SEC_MAX       2'h2
`define TBF_MAX_SECTIONS  3

`endif

// ### verif/tbf_checker.sv
`timescale 1ns/10ps
`default_nettype none
module tbf_checker (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        val_valid,
  input wire logic [31:0] val_data,
  input wire logic        val_ready,
  input wire logic [1:0]  val_section,
  input wire logic [7:0]  out_data,
  input wire logic        out_valid,
  input wire logic        out_ready,
  input wire logic        out_last,
  input wire logic        busy
);
  logic seen;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  always @(posedge clk_sys) begin
    if (!rst_n || !busy)
      seen <= 1'b0;
    else if (out_valid)
      seen <= 1'b1;
  end
  chk_first_hash: assert property (out_valid && !seen |-> out_data == 8'h23)
    else $error("first byte not hash");
  chk_hash_soon: assert property ($rose(busy) |-> ##[1:1000] out_valid)
    else $error("no byte after request");
  chk_hold_byte: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("byte dropped while stalled");
  chk_last_lf: assert property (out_last |-> out_valid && out_data == 8'h0A)
    else $error("last byte not linefeed");
  chk_idle_quiet: assert property (!busy |-> !out_valid)
    else $error("byte while idle");
  chk_sect_range: assert property (busy |-> val_section != 2'h3)
    else $error("section index out of range");
  chk_val_lsb: assert property (val_valid && val_ready |=> out_valid && out_data == $past(val_data[7:0]))
    else $error("value low byte not first");
  chk_val_second: assert property (val_valid && val_ready ##1 out_ready |=> out_data == $past(val_data[15:8], 2))
    else $error("value second byte wrong");
  chk_ready_busy: assert property (val_ready |-> busy)
    else $error("value taken while idle");
  chk_len_first: assert property ($rose(busy) |-> busy[*8])
    else $error("busy dropped during length work");
endmodule
`default_nettype wire

// ### verif/tbf_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module tbf_host_model (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       stall,
  input  wire logic [7:0] out_data,
  input  wire logic       out_valid,
  input  wire logic       out_last,
  output var  logic       out_ready
);
  logic [7:0] got[$];
  int         last_at;
  logic [1:0] phase;
  always @(posedge clk_sys) begin
    phase <= phase + 2'h1;
    if (!rst_n) begin
      out_ready <= 1'b0;
    end else begin
      // A slow host takes one byte in four, so the framer must hold its byte
      out_ready <= !stall || phase == 2'h3;
      if (out_valid && out_ready) begin
        got.push_back(out_data);
        if (out_last)
          last_at = got.size();
      end
    end
  end
endmodule
`default_nettype wire

// ### verif/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "tbf_map.vh"
module testbench;
  logic        clk_sys, rst_n, req_start, aux_min_sel, aux_max_sel, aux_max_is_random;
  logic        val_valid, val_ready, out_valid, out_ready, out_last, busy, stall;
  logic [15:0] value_count, g;
  logic [31:0] val_data;
  logic [1:0]  val_section;
  logic [7:0]  out_data;
  logic [7:0]  exp_q[$];
  int          bad_count, checks_done;
  tbf_framer tbf_framer_inst (.clk_sys, .rst_n, .req_start, .value_count, .aux_min_sel,
    .aux_max_sel, .aux_max_is_random, .val_valid, .val_data, .val_ready, .val_section,
    .out_data, .out_valid, .out_ready, .out_last, .busy);
  tbf_host_model tbf_host_model_inst (.clk_sys, .rst_n, .stall, .out_data, .out_valid,
    .out_last, .out_ready);
  // Value carries its section and running index so order errors show
  assign val_data = {6'h00, val_section, 8'h5C, g};
  always @(posedge clk_sys)
    if (val_valid && val_ready)
      g <= g + 16'h0001;
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic end_sim;
    $display("Comparisons %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  function automatic int ndig(input int v);
    ndig = 1;
    for (int p = 10; p <= v; p *= 10)
      ndig++;
  endfunction
  task automatic push_dec(input int v);
    int p;
    p = 1;
    exp_q.push_back(8'(8'h30 + ndig(v)));
    for (int i = 1; i < ndig(v); i++)
      p *= 10;
    for (; p > 0; p /= 10)
      exp_q.push_back(8'(8'h30 + (v / p) % 10));
  endtask
  task automatic run(input string nm, input int n, input logic mn, mx, rn, st);
    logic [1:0]  sec[$];
    logic [23:0] tag;
    logic [31:0] v;
    int          t;
    sec = {2'h0};
    if (mn)
      sec.push_back(2'h1);
    if (mx)
      sec.push_back(2'h2);
    exp_q = {`TBF_CHR_HASH};
    push_dec(sec.size() * (5 + ndig(n) + 4 * n));
    foreach (sec[s]) begin
      tag = sec[s] == 2'h0 ? `TBF_TAG_AVG : sec[s] == 2'h1 ? `TBF_TAG_MIN :
            rn ? `TBF_TAG_RND : `TBF_TAG_MAX;
      exp_q.push_back(tag[23:16]);
      exp_q.push_back(tag[15:8]);
      exp_q.push_back(tag[7:0]);
      exp_q.push_back(`TBF_CHR_TYPE_F);
      push_dec(n);
      for (int j = 0; j < n; j++) begin
        v = {6'h00, sec[s], 8'h5C, 16'(s * n + j)};
        for (int b = 0; b < 4; b++)
          exp_q.push_back(v[8*b +: 8]);
      end
    end
    exp_q.push_back(`TBF_CHR_LF);
    tbf_host_model_inst.got.delete();
    @(posedge clk_sys);
    req_start <= 1'b1;
    value_count <= 16'(n);
    aux_min_sel <= mn;
    aux_max_sel <= mx;
    aux_max_is_random <= rn;
    stall <= st;
    g <= 16'h0000;
    @(posedge clk_sys);
    req_start <= 1'b0;
    repeat (3) @(posedge clk_sys);
    req_start <= 1'b1;
    @(posedge clk_sys);
    req_start <= 1'b0;
    for (t = 0; t < 20000 && busy !== 1'b0; t++)
      @(posedge clk_sys);
    if (t == 20000) begin
      bad_count++;
      end_sim();
    end
    repeat (4) @(posedge clk_sys);
    check("idle after one response", busy, 1'b0);
    check("byte count", tbf_host_model_inst.got.size(), exp_q.size());
    check("last marker", tbf_host_model_inst.last_at, exp_q.size());
    foreach (exp_q[i])
      check("stream byte", tbf_host_model_inst.got[i], exp_q[i]);
    $display("Test %s done", nm);
  endtask
  task automatic test_avg_only;
    run("avg_only", 1, 1'b0, 1'b0, 1'b0, 1'b0);
  endtask
  task automatic test_three_stalled;
    run("three_stalled", 3, 1'b1, 1'b1, 1'b0, 1'b1);
  endtask
  task automatic test_random_tag;
    run("random_tag", 12, 1'b1, 1'b1, 1'b1, 1'b0);
  endtask
  task automatic test_max_empty;
    run("max_empty", 0, 1'b0, 1'b1, 1'b0, 1'b1);
  endtask
  task automatic test_min_hundred;
    run("min_hundred", 100, 1'b1, 1'b0, 1'b0, 1'b0);
  endtask
  initial begin
    rst_n = 1'b0;
    req_start = 1'b0;
    value_count = 16'h0000;
    aux_min_sel = 1'b0;
    aux_max_sel = 1'b0;
    aux_max_is_random = 1'b0;
    val_valid = 1'b1;
    stall = 1'b0;
    g = 16'h0000;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    test_avg_only();
    test_three_stalled();
    test_random_tag();
    test_max_empty();
    test_min_hundred();
    end_sim();
  end
endmodule
bind tbf_framer tbf_checker tbf_checker_inst (.clk_sys, .rst_n, .val_valid, .val_data,
  .val_ready, .val_section, .out_data, .out_valid, .out_ready, .out_last, .busy);
`default_nettype wire

// ### verilog/tbf_bcd_conv.v
`timescale 1ns/10ps
`default_nettype none

module tbf_bcd_conv #(
  parameter W  = 20,
  parameter D  = 7,
  parameter CW = 6
) (
  input  wire           clk_sys,
  input  wire           rst_n,
  input  wire           start,
  input  wire [W-1:0]   bin,
  output reg            done,
  output reg  [4*D-1:0] bcd,
  output reg  [3:0]     ndig
);

  reg  [W-1:0]   sh;
  reg  [CW-1:0]  cnt;
  reg            busy;
  reg  [4*D-1:0] adj;
  reg  [3:0]     used;
  integer        i;

  // Shift-and-add-three, one bit per cycle
  always @* begin
    adj  = bcd;
    used = 4'h1;
    for (i = 0; i < D; i = i + 1) begin
      if (bcd[4*i +: 4] > 4'h4)
        adj[4*i +: 4] = bcd[4*i +: 4] + 4'h3;
      if (bcd[4*i +: 4] != 4'h0)
        used = i[3:0] + 4'h1;
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      sh   <= {W{1'b0}};
      cnt  <= {CW{1'b0}};
      busy <= 1'b0;
      done <= 1'b0;
      bcd  <= {4*D{1'b0}};
      ndig <= 4'h1;
    end else begin
      done <= 1'b0;
      if (start) begin
        sh   <= bin;
        bcd  <= {4*D{1'b0}};
        cnt  <= W[CW-1:0];
        busy <= 1'b1;
      end else if (busy) begin
        if (cnt != {CW{1'b0}}) begin
          bcd <= {adj[4*D-2:0], sh[W-1]};
          sh  <= {sh[W-2:0], 1'b0};
          cnt <= cnt - {{CW-1{1'b0}}, 1'b1};
        end else begin
          busy <= 1'b0;
          done <= 1'b1;
          ndig <= used;
        end
      end
    end
  end

endmodule

`default_nettype wire

// ### verilog/tbf_framer.v
// Contract
// [RULE_01] Response opens with '#' and one digit counting the length digits.
// [RULE_02] Then that many length digits, that many content bytes, one linefeed.
// [RULE_03] At most three sections: average plus up to two auxiliaries.
// [RULE_04] Each section opens with a three-byte tag: AVG, MIN, MAX or RND.
// [RULE_05] Tag is followed by type byte 'f': four-byte float, LSB first.
// [RULE_06] Then one digit saying how many count digits follow.
// [RULE_07] Count field has that many digits and counts floats, not bytes.
// [RULE_08] Then the values themselves in the announced float format.
// [RULE_09] Content ends after average unless auxiliaries add further sections.
// [RULE_10] Order is average, minimum, maximum; four bytes per value.
// [RULE_11] Trace response honours the current auxiliary selection.
// [RULE_12] Content length sums tags, types, count headers, values before header.
`timescale 1ns/10ps
`default_nettype none
`include "tbf_map.vh"

module tbf_framer #(
  parameter CNT_W = 16,
  parameter CNT_D = 5,
  parameter LEN_D = 7
) (
  input  wire             clk_sys,
  input  wire             rst_n,
  input  wire             req_start,
  input  wire [CNT_W-1:0] value_count,
  input  wire             aux_min_sel,
  input  wire             aux_max_sel,
  input  wire             aux_max_is_random,
  input  wire             val_valid,
  input  wire [31:0]      val_data,
  output wire             val_ready,
  output reg  [1:0]       val_section,
  output reg  [7:0]       out_data,
  output reg              out_valid,
  input  wire             out_ready,
  output reg              out_last,
  output wire             busy
);

  localparam LEN_W = CNT_W + 4;

  localparam ST_IDLE = 4'h0;
  localparam ST_CONV = 4'h1;
  localparam ST_HASH = 4'h2;
  localparam ST_NLEN = 4'h3;
  localparam ST_LEN  = 4'h4;
  localparam ST_TAG  = 4'h5;
  localparam ST_TYPE = 4'h6;
  localparam ST_NCNT = 4'h7;
  localparam ST_CNT  = 4'h8;
  localparam ST_DATA = 4'h9;
  localparam ST_LF   = 4'hA;

  reg  [3:0]       state;
  reg  [CNT_W-1:0] n_vals;
  reg  [CNT_W-1:0] val_idx;
  reg  [2:0]       rem_mask;
  reg  [1:0]       nsec;
  reg              use_rnd;
  reg  [2:0]       dig;
  reg  [1:0]       byte_i;
  reg  [31:0]      word;
  reg              conv_go;

  wire             cnt_done;
  wire [4*CNT_D-1:0] cnt_bcd;
  wire [3:0]       cnt_ndig;
  wire             len_done;
  wire [4*LEN_D-1:0] len_bcd;
  wire [3:0]       len_ndig;

  wire             slot = !out_valid || out_ready;
  wire [2:0]       next_mask;
  reg  [1:0]       next_sec;
  reg  [23:0]      tag;
  reg  [LEN_W-1:0] sec_bytes;
  reg  [LEN_W-1:0] content_len;

  assign busy      = (state != ST_IDLE) || out_valid;
  assign val_ready = (state == ST_DATA) && (byte_i == 2'h0) && slot;
  assign next_mask = rem_mask & ~(3'b001 << val_section);

  // Per-section and total content size, known before the header goes out
  always @* begin
    sec_bytes = `TBF_SEC_FIXED + {{LEN_W-4{1'b0}}, cnt_ndig}
              + ({{4{1'b0}}, n_vals} << 2); // see [RULE_12] see [RULE_10]
    case (nsec)
      2'h3:    content_len = sec_bytes + (sec_bytes << 1); // see [RULE_12]
      2'h2:    content_len = sec_bytes << 1;
      default: content_len = sec_bytes;
    endcase
  end

  // Lowest remaining section comes next, keeping AVG, MIN, MAX order
  always @* begin
    if (next_mask[0])
      next_sec = `TBF_SEC_AVG; // see [RULE_10]
    else if (next_mask[1])
      next_sec = `TBF_SEC_MIN;
    else
      next_sec = `TBF_SEC_MAX;
  end

  always @* begin
    case (val_section)
      `TBF_SEC_AVG: tag = `TBF_TAG_AVG; // see [RULE_04]
      `TBF_SEC_MIN: tag = `TBF_TAG_MIN;
      default:      tag = use_rnd ? `TBF_TAG_RND : `TBF_TAG_MAX;
    endcase
  end

  tbf_bcd_conv #(
    .W  (CNT_W),
    .D  (CNT_D),
    .CW (6)
  ) u_cnt_conv (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .start   (conv_go),
    .bin     (n_vals),
    .done    (cnt_done),
    .bcd     (cnt_bcd),
    .ndig    (cnt_ndig)
  );

  // Length conversion waits for the count digits, which enter the size
  tbf_bcd_conv #(
    .W  (LEN_W),
    .D  (LEN_D),
    .CW (6)
  ) u_len_conv (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .start   (cnt_done),
    .bin     (content_len),
    .done    (len_done),
    .bcd     (len_bcd),
    .ndig    (len_ndig)
  );

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      state       <= ST_IDLE;
      n_vals      <= {CNT_W{1'b0}};
      val_idx     <= {CNT_W{1'b0}};
      rem_mask    <= 3'b000;
      nsec        <= 2'h1;
      use_rnd     <= 1'b0;
      dig         <= 3'h0;
      byte_i      <= 2'h0;
      word        <= 32'h0000_0000;
      conv_go     <= 1'b0;
      val_section <= `TBF_SEC_AVG;
      out_data    <= 8'h00;
      out_valid   <= 1'b0;
      out_last    <= 1'b0;
    end else begin
      conv_go <= 1'b0;
      if (out_valid && out_ready) begin
        out_valid <= 1'b0;
        out_last  <= 1'b0;
      end
      case (state)
        ST_IDLE: begin
          if (req_start) begin
            // Selection is sampled per request, so the last setting applies
            n_vals      <= value_count;
            rem_mask    <= {aux_max_sel, aux_min_sel, 1'b1}; // see [RULE_11] see [RULE_03]
            nsec        <= 2'h1 + {1'b0, aux_min_sel} + {1'b0, aux_max_sel}; // see [RULE_09]
            use_rnd     <= aux_max_is_random;
            val_section <= `TBF_SEC_AVG;
            conv_go     <= 1'b1;
            state       <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (len_done)
            state <= ST_HASH; // see [RULE_12]
        end
        ST_HASH: begin
          if (slot) begin
            out_data  <= `TBF_CHR_HASH; // see [RULE_01]
            out_valid <= 1'b1;
            state     <= ST_NLEN;
          end
        end
        ST_NLEN: begin
          if (slot) begin
            out_data  <= `TBF_CHR_ZERO + {4'h0, len_ndig}; // see [RULE_01]
            out_valid <= 1'b1;
            dig       <= len_ndig[2:0] - 3'h1;
            state     <= ST_LEN;
          end
        end
        ST_LEN: begin
          if (slot) begin
            out_data  <= `TBF_CHR_ZERO + {4'h0, len_bcd[dig*4 +: 4]}; // see [RULE_02]
            out_valid <= 1'b1;
            byte_i    <= 2'h0;
            if (dig == 3'h0)
              state <= ST_TAG;
            else
              dig <= dig - 3'h1;
          end
        end
        ST_TAG: begin
          if (slot) begin
            out_data  <= tag[23 - byte_i*8 -: 8]; // see [RULE_04]
            out_valid <= 1'b1;
            if (byte_i == `TBF_TAG_LEN - 1) begin
              byte_i <= 2'h0;
              state  <= ST_TYPE;
            end else begin
              byte_i <= byte_i + 2'h1;
            end
          end
        end
        ST_TYPE: begin
          if (slot) begin
            out_data  <= `TBF_CHR_TYPE_F; // see [RULE_05]
            out_valid <= 1'b1;
            state     <= ST_NCNT;
          end
        end
        ST_NCNT: begin
          if (slot) begin
            out_data  <= `TBF_CHR_ZERO + {4'h0, cnt_ndig}; // see [RULE_06]
            out_valid <= 1'b1;
            dig       <= cnt_ndig[2:0] - 3'h1;
            state     <= ST_CNT;
          end
        end
        ST_CNT: begin
          if (slot) begin
            out_data  <= `TBF_CHR_ZERO + {4'h0, cnt_bcd[dig*4 +: 4]}; // see [RULE_07]
            out_valid <= 1'b1;
            val_idx   <= {CNT_W{1'b0}};
            byte_i    <= 2'h0;
            if (dig != 3'h0) begin
              dig <= dig - 3'h1;
            end else if (n_vals != {CNT_W{1'b0}}) begin
              state <= ST_DATA; // see [RULE_08]
            end else begin
              // Empty section: nothing but its header
              rem_mask    <= next_mask;
              val_section <= next_sec;
              state       <= (next_mask == 3'b000) ? ST_LF : ST_TAG; // see [RULE_09]
            end
          end
        end
        ST_DATA: begin
          if (slot && (byte_i != 2'h0 || val_valid)) begin
            out_valid <= 1'b1;
            if (byte_i == 2'h0) begin
              out_data <= val_data[7:0]; // see [RULE_05]
              word     <= val_data;
            end else begin
              out_data <= word[byte_i*8 +: 8];
            end
            byte_i <= byte_i + 2'h1;
            if (byte_i == `TBF_VAL_BYTES - 1) begin // see [RULE_10]
              if (val_idx == n_vals - {{CNT_W-1{1'b0}}, 1'b1}) begin
                rem_mask    <= next_mask;
                val_section <= next_sec;
                state       <= (next_mask == 3'b000) ? ST_LF : ST_TAG; // see [RULE_09]
              end else begin
                val_idx <= val_idx + {{CNT_W-1{1'b0}}, 1'b1};
              end
            end
          end
        end
        ST_LF: begin
          if (slot) begin
            out_data  <= `TBF_CHR_LF; // see [RULE_02]
            out_valid <= 1'b1;
            out_last  <= 1'b1;
            state     <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire
